// ### core/glp_top.sv
// pin, LED and memory-pin configuration with AXI4-Lite registers
// assumes synchronous pin inputs and single-clock aclk at 125 MHz
`timescale 1ns/1ps
`include "glp_regs.svh"
// Behaviour
// - led_select bit set gives the pin to its LED source, else general purpose.
// - polarity one: high pin level sets its status bit.
// - polarity zero: low pin level sets its status bit.
// - status reaches the interrupt only when its enable bit is set.
// - levels must last at least 40 ns to register.
// - mem_pin_function picks what memory data and clock pins carry.
// - encodings per table; 010 and 100 reserved.
// - receive-valid and clocks come from internal PHY; transmit-enable from MAC.
// - push-pull bit set drives push-pull, clear gives open-drain.
// - direction bit set makes output; resets to input.
// - out-only data bits drive out-only pins 3 and 4.
// - push-pull output pins carry their written data bit; open-drain ones drive low for 0 and release for 1.
// - reading data bits 0 to 2 returns pin levels; out-only bits 3 and 4 read back as written.
module glp_top
    import glp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe_n,
    input wire logic [2:0] led_source,
    input wire glp_mii_t mii,
    input wire glp_mem_t mem,
    output logic mem_data_pin_out,
    output logic mem_data_pin_oe_n,
    output logic mem_clock_pin,
    output logic irq
);
    logic [31:0] cfg_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_enable_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [31:0] rdata_next;
    logic rd_ok;
    logic wr_fire;
    logic [2:0] pin_event;
    logic [2:0] sts_clear;
    glp_mem_t mem_pins;

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        return a == `GLP_CFG_OFFSET || a == `GLP_IRQ_STS_OFFSET ||
               a == `GLP_IRQ_EN_OFFSET;
    endfunction

    // write channel: address and data in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_known(awaddr_reg) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= `GLP_CFG_RESET;
        end else if (wr_fire && awaddr_reg == `GLP_CFG_OFFSET) begin
            cfg_reg <= strb_merge(cfg_reg, wdata_reg, wstrb_reg) & `GLP_CFG_WMASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_reg <= 3'h0;
        end else if (wr_fire && awaddr_reg == `GLP_IRQ_EN_OFFSET && wstrb_reg[0]) begin
            irq_enable_reg <= wdata_reg[2:0];
        end
    end

    // pin interrupt qualification, general-purpose pins only
    for (genvar g = 0; g < 3; g++) begin : g_filt
        logic ev;
        glp_pin_filter u_filt (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_level(pin_in[g]),
            .polarity(cfg_reg[`GLP_POL_LSB + g]),
            .event_pulse(ev)
        );
        assign pin_event[g] = ev && !cfg_reg[`GLP_LED_LSB + g];
    end

    assign sts_clear = (wr_fire && awaddr_reg == `GLP_IRQ_STS_OFFSET && wstrb_reg[0])
                       ? wdata_reg[2:0] : 3'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= 3'h0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~sts_clear) | pin_event;
        end
    end

    assign irq = |(irq_status_reg & irq_enable_reg);

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_ok = addr_known(s_axi_araddr);

    always_comb begin
        rdata_next = 32'h00000000;
        if (s_axi_araddr == `GLP_CFG_OFFSET) begin
            rdata_next = cfg_reg;
            rdata_next[`GLP_DATA_LSB +: 3] = pin_in;
        end else if (s_axi_araddr == `GLP_IRQ_STS_OFFSET) begin
            rdata_next[2:0] = irq_status_reg;
        end else if (s_axi_araddr == `GLP_IRQ_EN_OFFSET) begin
            rdata_next[2:0] = irq_enable_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // bidirectional pin drive
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (cfg_reg[`GLP_LED_LSB + i]) begin
                pin_out[i] = led_source[i];
                pin_oe_n[i] = 1'b0;
            end else if (!cfg_reg[`GLP_DIR_LSB + i]) begin
                pin_out[i] = 1'b0;
                pin_oe_n[i] = 1'b1;
            end else if (cfg_reg[`GLP_PUSH_PULL_LSB + i]) begin
                pin_out[i] = cfg_reg[`GLP_DATA_LSB + i];
                pin_oe_n[i] = 1'b0;
            end else begin
                pin_out[i] = 1'b0;
                pin_oe_n[i] = cfg_reg[`GLP_DATA_LSB + i];
            end
        end
    end

    glp_mux u_mux (
        .func(glp_func_t'(cfg_reg[`GLP_FUNC_LSB +: 3])),
        .mem(mem),
        .mii(mii),
        .out_only(cfg_reg[`GLP_OUT_ONLY_LSB +: 2]),
        .pins(mem_pins)
    );

    assign mem_data_pin_out = mem_pins.data_out;
    assign mem_data_pin_oe_n = mem_pins.data_oe_n;
    assign mem_clock_pin = mem_pins.clk_out;
endmodule // glp_top

// ### core/glp_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name wherever one of its macros is read
`ifndef GLP_REGS_SVH
`define GLP_REGS_SVH
`define GLP_CFG_OFFSET 8'h88
`define GLP_IRQ_STS_OFFSET 8'h58
`define GLP_IRQ_EN_OFFSET 8'h5C
`define GLP_DATA_LSB 0
`define GLP_OUT_ONLY_LSB 3
`define GLP_DIR_LSB 8
`define GLP_PUSH_PULL_LSB 16
`define GLP_FUNC_LSB 20
`define GLP_POL_LSB 24
`define GLP_LED_LSB 28
`define GLP_CFG_WMASK 32'h7777071F
`define GLP_CFG_RESET 32'h00000000
`define GLP_MIN_ACTIVE_NS 40
`define GLP_CLK_PERIOD_NS 8
`define GLP_MIN_ACTIVE_CYC ((`GLP_MIN_ACTIVE_NS + `GLP_CLK_PERIOD_NS - 1) / `GLP_CLK_PERIOD_NS)
`endif

// ### core/glp_pkg.sv
// types shared by the pin configuration block
// assumes glp_regs.svh sits beside it
package glp_pkg;
`include "glp_regs.svh"
    typedef enum logic [2:0] {
        GLP_FN_MEM = 3'h0,
        GLP_FN_OUT_OUT = 3'h1,
        GLP_FN_RSV2 = 3'h2,
        GLP_FN_OUT_RXDV = 3'h3,
        GLP_FN_RSV4 = 3'h4,
        GLP_FN_TXEN_OUT = 3'h5,
        GLP_FN_TXEN_RXDV = 3'h6,
        GLP_FN_CLKS = 3'h7
    } glp_func_t;
    typedef struct packed {
        logic tx_en;
        logic tx_clk;
        logic rx_clk;
        logic rx_dv;
    } glp_mii_t;
    typedef struct packed {
        logic data_out;
        logic data_oe_n;
        logic clk_out;
    } glp_mem_t;
endpackage

// ### core/glp_pin_filter.sv
// per-pin active-level qualifier for the pin interrupt
// assumes pin levels synchronous to aclk
`timescale 1ns/1ps
`include "glp_regs.svh"
module glp_pin_filter
    import glp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_level,
    input wire logic polarity,
    output logic event_pulse
);
    logic [3:0] cnt_reg;
    logic active;
    assign active = (pin_level == polarity);
    // level match, must hold min time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 4'h0;
        end else if (!active) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg < 4'(`GLP_MIN_ACTIVE_CYC)) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // level-sensitive: keeps asserting while the level stays
    assign event_pulse = (cnt_reg == 4'(`GLP_MIN_ACTIVE_CYC));
endmodule // glp_pin_filter

// ### core/glp_mux.sv
// memory-pin function selector
// assumes mii signals already on aclk
`timescale 1ns/1ps
module glp_mux
    import glp_pkg::*;
(
    input wire glp_func_t func,
    input wire glp_mem_t mem,
    input wire glp_mii_t mii,
    input wire logic [1:0] out_only,
    output glp_mem_t pins
);
    always_comb begin
        pins = '{data_out: 1'b0, data_oe_n: 1'b0, clk_out: 1'b0};
        unique case (func)
            GLP_FN_MEM: pins = mem;
            GLP_FN_OUT_OUT: pins = '{data_out: out_only[0], data_oe_n: 1'b0,
                clk_out: out_only[1]};
            GLP_FN_OUT_RXDV: pins = '{data_out: out_only[0], data_oe_n: 1'b0,
                clk_out: mii.rx_dv};
            GLP_FN_TXEN_OUT: pins = '{data_out: mii.tx_en, data_oe_n: 1'b0,
                clk_out: out_only[1]};
            GLP_FN_TXEN_RXDV: pins = '{data_out: mii.tx_en, data_oe_n: 1'b0,
                clk_out: mii.rx_dv};
            GLP_FN_CLKS: pins = '{data_out: mii.tx_clk, data_oe_n: 1'b0,
                clk_out: mii.rx_clk};
            // reserved codes release the data pin
            default: pins = '{data_out: 1'b0, data_oe_n: 1'b1, clk_out: 1'b0};
        endcase
    end
endmodule // glp_mux

// ### dv/glp_top_asserts.sv
// bus handshake and reset checks for the pin configuration block
// assumes binding to glp_top, one aclk domain
`timescale 1ns/1ps
module glp_top_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] pin_oe_n,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer not held");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    // the reset checks run inside reset, so the default disable is lifted
    AST_OE_RESET: assert property (disable iff (1'b0) !aresetn |=> pin_oe_n == 3'h7)
        else $error("pins not released by reset");
    AST_IRQ_RESET: assert property (disable iff (1'b0) !aresetn |=> !irq)
        else $error("interrupt high after reset");
endmodule // glp_top_asserts

// ### dv/glp_pin_model.sv
// external loads on the three shared pins
// assumes the bench sets the level a released pin settles to
`timescale 1ns/1ps
module glp_pin_model (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    input wire logic [2:0] ext_level,
    output logic [2:0] pin_level
);
    always_comb pin_level = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule // glp_pin_model

// ### dv/glp_top_bench.sv
// self-checking bench for glp_top with pin loads
// assumes the checker and pin model compiled before it
`timescale 1ns/1ps
`include "glp_regs.svh"
module glp_top_bench import glp_pkg::*;;
    typedef struct packed {
        logic [31:0] cfg;
        logic [2:0] oe;
        logic [2:0] drv;
        logic [2:0] mp;
        logic [31:0] rb;
    } glp_row_t;
    localparam logic [7:0] CF = `GLP_CFG_OFFSET;
    localparam logic [7:0] ST = `GLP_IRQ_STS_OFFSET;
    localparam logic [7:0] EN = `GLP_IRQ_EN_OFFSET;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic [2:0] pin_in, pin_out, pin_oe_n, led_source, ext;
    logic mem_data_pin_out, mem_data_pin_oe_n, mem_clock_pin;
    glp_mii_t mii;
    glp_mem_t mem;
    int n_errors, n_tests;
    // mii 1010: tx_en 1, tx_clk 0, rx_clk 1, rx_dv 0; mem drives data 1, clock 0
    // legal codes, memory idle
    glp_row_t rows [9] = '{
        '{32'h00000707, 3'h7, 3'h0, 3'h4, 32'h00000702},
        '{32'h00070705, 3'h0, 3'h5, 3'h4, 32'h00070705},
        '{32'h00010102, 3'h6, 3'h0, 3'h4, 32'h00010102},
        '{32'h8898F8F8, 3'h7, 3'h0, 3'h5, 32'h0010001A},
        '{32'h00300008, 3'h7, 3'h0, 3'h4, 32'h0030000A},
        '{32'h00500010, 3'h7, 3'h0, 3'h5, 32'h00500012},
        '{32'h00600000, 3'h7, 3'h0, 3'h4, 32'h00600002},
        '{32'h00700000, 3'h7, 3'h0, 3'h1, 32'h00700002},
        '{32'h00000000, 3'h7, 3'h0, 3'h4, 32'h00000002}};
    glp_top glp_top_inst (.*);
    glp_pin_model glp_pin_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_level(ext), .pin_level(pin_in));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 99) begin
            n_errors++;
            give_verdict;
        end
    endtask
    // entered just after a rising edge; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        n = 0;
        while ((pa || pw) && n < 99) begin
            @(negedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            n++;
            @(posedge aclk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do begin @(negedge aclk); n++; end while (!s_axi_bvalid && n < 99);
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        hang(n);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        n = 0;
        do begin @(negedge aclk); n++; end while (!s_axi_arready && n < 99);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge aclk); n++; end while (!s_axi_rvalid && n < 99);
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        hang(n);
    endtask
    // irq is looked at mid-cycle, clear of the edge that updates it
    task automatic chk_irq(input logic exp);
        @(negedge aclk);
        chk("irq", {31'h0, irq}, {31'h0, exp});
        @(posedge aclk);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, led_source} = '0;
        s_axi_wstrb = 4'hF;
        ext = 3'h2;
        mii = 4'hA;
        mem = 3'h4;
        n_errors = 0;
        n_tests = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 9; i++) begin
            wr(CF, rows[i].cfg);
            chk("cfg wresp", {30'h0, br}, 32'h0);
            rd_reg(CF);
            chk("cfg read", rd, rows[i].rb);
            chk("pin enable", {29'h0, pin_oe_n}, {29'h0, rows[i].oe});
            chk("pin drive", {29'h0, pin_out & ~pin_oe_n}, {29'h0, rows[i].drv});
            chk("mem pins", {29'h0, mem_data_pin_out, mem_data_pin_oe_n, mem_clock_pin},
                {29'h0, rows[i].mp});
            $display("row %0d done", i);
        end
        $display("table done");
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset enable", {29'h0, pin_oe_n}, 32'h7);
        rd_reg(CF);
        chk("reset cfg", rd, 32'h2);
        rd_reg(8'h10);
        chk("unmapped resp", {30'h0, rr}, 32'h2);
        wr(8'h10, 32'h00000707);
        chk("unmapped wresp", {30'h0, br}, 32'h2);
        rd_reg(CF);
        chk("ignored write", rd, 32'h2);
        $display("reset done");
        led_source <= 3'h5;
        wr(CF, 32'h70000000);
        chk("led enable", {29'h0, pin_oe_n}, 32'h0);
        chk("led drive", {29'h0, pin_out}, 32'h5);
        wr(CF, 32'h0);
        $display("led done");
        wr(ST, 32'h7);
        rd_reg(ST);
        chk("low status", rd, 32'h5);
        chk_irq(1'b0);
        wr(EN, 32'h1);
        chk_irq(1'b1);
        wr(CF, 32'h07000000);
        wr(ST, 32'h7);
        rd_reg(ST);
        chk("high status", rd, 32'h2);
        chk_irq(1'b0);
        ext <= 3'h0;
        wr(ST, 32'h7);
        ext <= 3'h1;
        repeat (2) @(posedge aclk);
        ext <= 3'h0;
        repeat (8) @(posedge aclk);
        rd_reg(ST);
        chk("short pulse", rd, 32'h0);
        ext <= 3'h1;
        repeat (8) @(posedge aclk);
        rd_reg(ST);
        chk("long pulse", rd, 32'h1);
        chk_irq(1'b1);
        wr(EN, 32'h0);
        chk_irq(1'b0);
        $display("interrupt done");
        give_verdict;
    end
endmodule // glp_top_bench
bind glp_top glp_top_asserts glp_top_asserts_inst (.*);
